// ===== hdl/bop_pkg.sv
// constants, encodings and register map of the bit-op execution block
package bop_pkg;
   localparam int DW = 8;
   localparam int AW = 12;
   localparam int NREG = 16;
   localparam int NIO = 16;
   localparam int NPTR = 3;
   localparam int MEMD = 256;
   // apb byte addresses and decode masks (low two bits force alignment)
   localparam logic [11:0] CMD_ADDR = 12'h000;
   localparam logic [11:0] FLAGS_ADDR = 12'h004;
   localparam logic [11:0] STAT_ADDR = 12'h008;
   localparam logic [11:0] PTR_BASE = 12'h010;
   localparam logic [11:0] PTR_MASK = 12'hFF3;
   localparam logic [11:0] WREG_BASE = 12'h040;
   localparam logic [11:0] WREG_MASK = 12'hFC3;
   localparam logic [11:0] IO_BASE = 12'h080;
   localparam logic [11:0] IO_MASK = 12'hFC3;
   localparam logic [11:0] MEM_BASE = 12'h400;
   localparam logic [11:0] MEM_MASK = 12'hC03;
   localparam int IDX_LO = 2;
   localparam int PIDX_HI = 3;
   localparam int RIDX_HI = 5;
   localparam int MIDX_HI = 9;
   // command word fields
   localparam int OP_LO = 0;
   localparam int OP_HI = 3;
   localparam int BIT_LO = 4;
   localparam int BIT_HI = 6;
   localparam int REG_LO = 8;
   localparam int REG_HI = 11;
   localparam int IOS_LO = 12;
   localparam int IOS_HI = 15;
   localparam int PSEL_LO = 16;
   localparam int PSEL_HI = 17;
   // operations
   localparam logic [3:0] IO_BIT_SET_OP = 4'h0;
   localparam logic [3:0] IO_BIT_CLEAR_OP = 4'h1;
   localparam logic [3:0] LOGICAL_LEFT_SHIFT_OP = 4'h2;
   localparam logic [3:0] LOGICAL_RIGHT_SHIFT_OP = 4'h3;
   localparam logic [3:0] ARITH_RIGHT_SHIFT_OP = 4'h4;
   localparam logic [3:0] ROTATE_LEFT_CARRY_OP = 4'h5;
   localparam logic [3:0] ROTATE_RIGHT_CARRY_OP = 4'h6;
   localparam logic [3:0] NIBBLE_SWAP_OP = 4'h7;
   localparam logic [3:0] INDEXED_FLAG_SET_OP = 4'h8;
   localparam logic [3:0] INDEXED_FLAG_CLEAR_OP = 4'h9;
   localparam logic [3:0] BIT_TO_TRANSFER_FLAG_OP = 4'hA;
   localparam logic [3:0] TRANSFER_FLAG_TO_BIT_OP = 4'hB;
   localparam logic [3:0] INDIRECT_LOAD_INC_OP = 4'hC;
   localparam logic [3:0] INDIRECT_LOAD_DEC_OP = 4'hD;
   localparam logic [3:0] GLOBAL_IRQ_ON_OP = 4'hE;
   localparam logic [3:0] GLOBAL_IRQ_OFF_OP = 4'hF;
   // flags_ff bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [1:0] PTR_LAST = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EX1 = 3'b010,
      ST_EX2 = 3'b100
   } bop_state_t;
endpackage

// ===== hdl/bop_exec.sv
// bit-op, flag and indirect-load execution unit behind an apb slave
`timescale 1ns/1ps
// Contract
// - io bit set, flags kept, two cycles
// - io bit clear, flags kept, two cycles
// - shifts one cycle, update z c n v
// - rotates through carry, one cycle, zcnv
// - flag set writes one flag, one cycle
// - flag clear writes one flag, one cycle
// - irq enable/disable touches only i flag
// - register bit copied into transfer flag
// - transfer flag to bit; nibble swap; flags kept
// - load then pointer increment, two cycles
// - pointer decrement then load, two cycles
module bop_exec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy,
   output logic done
);
   bop_pkg::bop_state_t state_ff;
   bop_pkg::bop_state_t nxt_state;
   logic [7:0] wreg_ff [bop_pkg::NREG];
   logic [7:0] io_ff [bop_pkg::NIO];
   logic [7:0] ptr_ff [bop_pkg::NPTR];
   logic [7:0] mem [bop_pkg::MEMD];
   logic [7:0] flags_ff;
   logic [3:0] op_ff;
   logic [2:0] bit_ff;
   logic [3:0] reg_ff;
   logic [3:0] iosel_ff;
   logic [1:0] psel_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic done_ff;
   logic busy_ff;
   logic ok_ff;
   logic setup;
   logic acc_wr;
   logic is_cmd;
   logic is_flags;
   logic is_stat;
   logic is_ptr;
   logic is_wreg;
   logic is_io;
   logic is_mem;
   logic addr_err;
   logic [31:0] nxt_rdata;
   logic [7:0] opd;
   logic [7:0] ptr_val;
   logic [7:0] mem_rd;
   logic [7:0] sh_res;
   logic sh_c;
   logic sh_op;
   logic [1:0] pidx;
   logic [3:0] ridx;
   logic [7:0] midx;

   assign pidx = paddr[bop_pkg::PIDX_HI:bop_pkg::IDX_LO];
   assign ridx = paddr[bop_pkg::RIDX_HI:bop_pkg::IDX_LO];
   assign midx = paddr[bop_pkg::MIDX_HI:bop_pkg::IDX_LO];
   assign setup = psel & ~penable;
   assign acc_wr = psel & penable & pready_ff & pwrite & ok_ff;
   assign is_cmd = (paddr == bop_pkg::CMD_ADDR);
   assign is_flags = (paddr == bop_pkg::FLAGS_ADDR);
   assign is_stat = (paddr == bop_pkg::STAT_ADDR);
   assign is_ptr = ((paddr & bop_pkg::PTR_MASK) == bop_pkg::PTR_BASE)
      && (pidx <= bop_pkg::PTR_LAST);
   assign is_wreg = ((paddr & bop_pkg::WREG_MASK) == bop_pkg::WREG_BASE);
   assign is_io = ((paddr & bop_pkg::IO_MASK) == bop_pkg::IO_BASE);
   assign is_mem = ((paddr & bop_pkg::MEM_MASK) == bop_pkg::MEM_BASE);
   // unmapped address, or a command while one is still running
   assign addr_err = !(is_cmd | is_flags | is_stat | is_ptr | is_wreg
      | is_io | is_mem) | (is_cmd & pwrite & (state_ff != bop_pkg::ST_IDLE));

   // read mux
   always_comb begin
      nxt_rdata = bop_pkg::WORD_ZERO;
      if (is_cmd) begin
         nxt_rdata[bop_pkg::PSEL_HI:bop_pkg::OP_LO] =
            {psel_ff, iosel_ff, reg_ff, 1'b0, bit_ff, op_ff};
      end else if (is_flags) begin
         nxt_rdata[7:0] = flags_ff;
      end else if (is_stat) begin
         nxt_rdata[0] = (state_ff != bop_pkg::ST_IDLE);
      end else if (is_ptr) begin
         nxt_rdata[7:0] = ptr_ff[pidx];
      end else if (is_wreg) begin
         nxt_rdata[7:0] = wreg_ff[ridx];
      end else if (is_io) begin
         nxt_rdata[7:0] = io_ff[ridx];
      end else if (is_mem) begin
         nxt_rdata[7:0] = mem[midx];
      end
   end

   // apb answer: one wait-free access phase after each setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= bop_pkg::WORD_ZERO;
         ok_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            pslverr_ff <= addr_err;
            ok_ff <= ~addr_err;
            prdata_ff <= pwrite ? bop_pkg::WORD_ZERO : nxt_rdata;
         end else begin
            pslverr_ff <= 1'b0;
            ok_ff <= 1'b0;
            prdata_ff <= bop_pkg::WORD_ZERO;
         end
      end
   end

   // operand and shift unit
   assign opd = wreg_ff[reg_ff];
   assign ptr_val = ptr_ff[psel_ff];
   assign mem_rd = mem[ptr_val];
   assign sh_op = (op_ff >= bop_pkg::LOGICAL_LEFT_SHIFT_OP)
      && (op_ff <= bop_pkg::ROTATE_RIGHT_CARRY_OP);
   always_comb begin
      sh_res = opd;
      sh_c = flags_ff[bop_pkg::FLG_C];
      case (op_ff)
         bop_pkg::LOGICAL_LEFT_SHIFT_OP: begin
            sh_res = {opd[6:0], 1'b0};
            sh_c = opd[7];
         end
         bop_pkg::LOGICAL_RIGHT_SHIFT_OP: begin
            sh_res = {1'b0, opd[7:1]};
            sh_c = opd[0];
         end
         bop_pkg::ARITH_RIGHT_SHIFT_OP: begin
            sh_res = {opd[7], opd[7:1]};
            sh_c = opd[0];
         end
         bop_pkg::ROTATE_LEFT_CARRY_OP: begin
            sh_res = {opd[6:0], flags_ff[bop_pkg::FLG_C]};
            sh_c = opd[7];
         end
         bop_pkg::ROTATE_RIGHT_CARRY_OP: begin
            sh_res = {flags_ff[bop_pkg::FLG_C], opd[7:1]};
            sh_c = opd[0];
         end
         default: begin
            sh_res = opd;
            sh_c = flags_ff[bop_pkg::FLG_C];
         end
      endcase
   end

   // sequencer: two-cycle ops pass through the second state
   always_comb begin
      case (state_ff)
         bop_pkg::ST_IDLE:
            nxt_state = (acc_wr && is_cmd) ? bop_pkg::ST_EX1 : bop_pkg::ST_IDLE;
         bop_pkg::ST_EX1:
            nxt_state = (op_ff <= bop_pkg::IO_BIT_CLEAR_OP
               || op_ff == bop_pkg::INDIRECT_LOAD_INC_OP
               || op_ff == bop_pkg::INDIRECT_LOAD_DEC_OP)
               ? bop_pkg::ST_EX2 : bop_pkg::ST_IDLE;
         default: nxt_state = bop_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= bop_pkg::ST_IDLE;
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= (nxt_state != bop_pkg::ST_IDLE);
         done_ff <= (state_ff != bop_pkg::ST_IDLE)
            && (nxt_state == bop_pkg::ST_IDLE);
      end
   end

   // command latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_ff <= bop_pkg::IO_BIT_SET_OP;
         bit_ff <= 3'h0;
         reg_ff <= 4'h0;
         iosel_ff <= 4'h0;
         psel_ff <= 2'h0;
      end else if (acc_wr && is_cmd) begin
         op_ff <= pwdata[bop_pkg::OP_HI:bop_pkg::OP_LO];
         bit_ff <= pwdata[bop_pkg::BIT_HI:bop_pkg::BIT_LO];
         reg_ff <= pwdata[bop_pkg::REG_HI:bop_pkg::REG_LO];
         iosel_ff <= pwdata[bop_pkg::IOS_HI:bop_pkg::IOS_LO];
         psel_ff <= (pwdata[bop_pkg::PSEL_HI:bop_pkg::PSEL_LO] >
            bop_pkg::PTR_LAST) ? bop_pkg::PTR_LAST
            : pwdata[bop_pkg::PSEL_HI:bop_pkg::PSEL_LO];
      end
   end

   // status flags; execution wins over a bus write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= bop_pkg::FLAGS_RST;
      end else if (state_ff == bop_pkg::ST_EX1) begin
         if (sh_op) begin
            flags_ff[bop_pkg::FLG_C] <= sh_c;
            flags_ff[bop_pkg::FLG_Z] <= (sh_res == bop_pkg::BYTE_ZERO);
            flags_ff[bop_pkg::FLG_N] <= sh_res[7];
            flags_ff[bop_pkg::FLG_V] <= sh_res[7] ^ sh_c;
         end
         if (op_ff == bop_pkg::INDEXED_FLAG_SET_OP) begin
            flags_ff[bit_ff] <= 1'b1;
         end
         if (op_ff == bop_pkg::INDEXED_FLAG_CLEAR_OP) begin
            flags_ff[bit_ff] <= 1'b0;
         end
         if (op_ff == bop_pkg::GLOBAL_IRQ_ON_OP) begin
            flags_ff[bop_pkg::FLG_I] <= 1'b1;
         end
         if (op_ff == bop_pkg::GLOBAL_IRQ_OFF_OP) begin
            flags_ff[bop_pkg::FLG_I] <= 1'b0;
         end
         if (op_ff == bop_pkg::BIT_TO_TRANSFER_FLAG_OP) begin
            flags_ff[bop_pkg::FLG_T] <= opd[bit_ff];
         end
      end else if (acc_wr && is_flags) begin
         flags_ff <= pwdata[7:0];
      end
   end

   // working, io and pointer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < bop_pkg::NREG; i++) begin
            wreg_ff[i] <= bop_pkg::BYTE_ZERO;
            io_ff[i] <= bop_pkg::BYTE_ZERO;
         end
         for (int i = 0; i < bop_pkg::NPTR; i++) begin
            ptr_ff[i] <= bop_pkg::BYTE_ZERO;
         end
      end else if (state_ff == bop_pkg::ST_EX1) begin
         if (sh_op) begin
            wreg_ff[reg_ff] <= sh_res;
         end
         if (op_ff == bop_pkg::NIBBLE_SWAP_OP) begin
            wreg_ff[reg_ff] <= {opd[3:0], opd[7:4]};
         end
         if (op_ff == bop_pkg::TRANSFER_FLAG_TO_BIT_OP) begin
            wreg_ff[reg_ff][bit_ff] <= flags_ff[bop_pkg::FLG_T];
         end
         if (op_ff == bop_pkg::INDIRECT_LOAD_INC_OP) begin
            wreg_ff[reg_ff] <= mem_rd;
         end
         if (op_ff == bop_pkg::INDIRECT_LOAD_DEC_OP) begin
            ptr_ff[psel_ff] <= ptr_val - bop_pkg::PTR_STEP;
         end
      end else if (state_ff == bop_pkg::ST_EX2) begin
         // io bit write in second cycle
         if (op_ff == bop_pkg::IO_BIT_SET_OP) begin
            io_ff[iosel_ff][bit_ff] <= 1'b1;
         end
         if (op_ff == bop_pkg::IO_BIT_CLEAR_OP) begin
            io_ff[iosel_ff][bit_ff] <= 1'b0;
         end
         if (op_ff == bop_pkg::INDIRECT_LOAD_INC_OP) begin
            ptr_ff[psel_ff] <= ptr_val + bop_pkg::PTR_STEP;
         end
         if (op_ff == bop_pkg::INDIRECT_LOAD_DEC_OP) begin
            wreg_ff[reg_ff] <= mem_rd;
         end
      end else if (acc_wr) begin
         if (is_wreg) begin
            wreg_ff[ridx] <= pwdata[7:0];
         end
         if (is_io) begin
            io_ff[ridx] <= pwdata[7:0];
         end
         if (is_ptr) begin
            ptr_ff[pidx] <= pwdata[7:0];
         end
      end
   end

   // data memory, filled over the bus only
   always_ff @(posedge pclk) begin
      if (acc_wr && is_mem) begin
         mem[midx] <= pwdata[7:0];
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign busy = busy_ff;
   assign done = done_ff;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic ex1;
   assign ex1 = (state_ff == bop_pkg::ST_EX1);
   logic [15:0] ex_op;
   assign ex_op = ex1 ? (16'h0001 << op_ff) : 16'h0000;

   AST_IO_SET: assert property (ex_op[bop_pkg::IO_BIT_SET_OP]
      |=> $stable(flags_ff) ##1 io_ff[iosel_ff][bit_ff] && done_ff)
      else $error("io bit set wrong");
   AST_IO_CLR: assert property (ex_op[bop_pkg::IO_BIT_CLEAR_OP]
      |=> state_ff == bop_pkg::ST_EX2 ##1 !io_ff[iosel_ff][bit_ff])
      else $error("io bit clear wrong");
   AST_LSL: assert property (ex_op[bop_pkg::LOGICAL_LEFT_SHIFT_OP]
      |=> !wreg_ff[reg_ff][0] && flags_ff[bop_pkg::FLG_C] == $past(opd[7])
      && done_ff)
      else $error("left shift wrong");
   AST_ROR: assert property (ex_op[bop_pkg::ROTATE_RIGHT_CARRY_OP]
      |=> wreg_ff[reg_ff][7] == $past(flags_ff[bop_pkg::FLG_C])
      && flags_ff[bop_pkg::FLG_C] == $past(opd[0]))
      else $error("rotate right wrong");
   AST_FSET: assert property (ex_op[bop_pkg::INDEXED_FLAG_SET_OP]
      |=> flags_ff[bit_ff] && !busy)
      else $error("flag set wrong");
   AST_FCLR: assert property (ex_op[bop_pkg::INDEXED_FLAG_CLEAR_OP]
      |=> !flags_ff[bit_ff] && !busy)
      else $error("flag clear wrong");
   AST_SEI: assert property (ex_op[bop_pkg::GLOBAL_IRQ_ON_OP]
      |=> flags_ff == {1'b1, $past(flags_ff[6:0])})
      else $error("irq enable wrong");
   AST_BST: assert property (ex_op[bop_pkg::BIT_TO_TRANSFER_FLAG_OP]
      |=> flags_ff[bop_pkg::FLG_T] == $past(opd[bit_ff]))
      else $error("bit store wrong");
   AST_SWAP: assert property (ex_op[bop_pkg::NIBBLE_SWAP_OP]
      |=> wreg_ff[reg_ff] == {$past(opd[3:0]), $past(opd[7:4])}
      && $stable(flags_ff))
      else $error("swap wrong");
   AST_LDINC: assert property (ex_op[bop_pkg::INDIRECT_LOAD_INC_OP]
      |=> wreg_ff[reg_ff] == $past(mem_rd)
      ##1 ptr_val == 8'($past(ptr_val, 2) + bop_pkg::PTR_STEP))
      else $error("post-increment load wrong");
   AST_LDDEC: assert property (ex_op[bop_pkg::INDIRECT_LOAD_DEC_OP]
      |=> ptr_val == 8'($past(ptr_val) - bop_pkg::PTR_STEP)
      ##1 wreg_ff[reg_ff] == $past(mem_rd))
      else $error("pre-decrement load wrong");
   COV_IO: cover property (ex1 && op_ff == bop_pkg::IO_BIT_SET_OP ##2 done_ff);
   COV_ROL: cover property (ex1 && op_ff == bop_pkg::ROTATE_LEFT_CARRY_OP);
   COV_LD: cover property (ex1 && op_ff == bop_pkg::INDIRECT_LOAD_DEC_OP);
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the bit-op execution unit
`timescale 1ns/1ps
module tb_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic done;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] rnd = 32'h0000_887e;
   logic [31:0] rd;
   logic er;
   logic [15:0] s;
   logic [31:0] c;

   bop_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy), .done(done));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [11:0] addr(input logic [11:0] base,
         input logic [7:0] i);
      return base | {2'b00, i, 2'b00};
   endfunction

   function automatic logic [31:0] mk(input logic [3:0] op,
         input logic [2:0] b, input logic [3:0] rg, input logic [3:0] io,
         input logic [1:0] p);
      return {14'h0000, p, io, rg, 1'b0, b, op};
   endfunction

   // expected {flags, result} of a shift or rotate
   function automatic logic [15:0] sh_ref(input logic [3:0] op,
         input logic [7:0] x, input logic [7:0] f);
      logic [7:0] y;
      logic c;
      case (op)
         bop_pkg::LOGICAL_LEFT_SHIFT_OP: {c, y} = {x, 1'b0};
         bop_pkg::LOGICAL_RIGHT_SHIFT_OP: {y, c} = {1'b0, x};
         bop_pkg::ARITH_RIGHT_SHIFT_OP: {y, c} = {x[7], x};
         bop_pkg::ROTATE_LEFT_CARRY_OP: {c, y} = {x, f[bop_pkg::FLG_C]};
         default: {y, c} = {f[bop_pkg::FLG_C], x};
      endcase
      f[bop_pkg::FLG_C] = c;
      f[bop_pkg::FLG_Z] = (y == 8'h00);
      f[bop_pkg::FLG_N] = y[7];
      f[bop_pkg::FLG_V] = y[7] ^ c;
      return {f, y};
   endfunction

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         $display("[ERR] timeout exp 0 got %0d", cyc);
         final_report();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e,
         input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_cyc(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         failures++;
         $display("[ERR] %s exp %0d got %0d", nm, e, g);
      end
   endtask

   // apb transfer, read data taken at the pready edge
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h00_0000, d});
   endtask

   task automatic rdc(input string nm, input logic [11:0] a,
         input logic [7:0] e);
      xfer(1'b0, a, bop_pkg::WORD_ZERO);
      chk8(nm, e, rd[7:0]);
   endtask

   // issue a command and count its busy cycles
   task automatic run(input logic [31:0] c, input int ecyc);
      int n;
      n = 0;
      xfer(1'b1, bop_pkg::CMD_ADDR, c);
      for (int i = 0; i < 12; i++) begin
         @(negedge pclk);
         if (busy === 1'b1) n++;
         if (done === 1'b1) break;
      end
      chk_cyc("busy cycles", ecyc, n);
      chk8("done", 8'h01, {7'h00, done});
   endtask

   initial begin
      logic [7:0] f;
      logic [7:0] x;
      logic [7:0] m;
      logic [2:0] b;
      logic [3:0] g;
      logic [3:0] op;
      logic [11:0] pa;
      logic [11:0] bad [3];
      bad = '{12'h00C, 12'h01C, 12'h041};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = bop_pkg::WORD_ZERO;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc("flags reset", bop_pkg::FLAGS_ADDR, bop_pkg::FLAGS_RST);
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr_nx(rnd);
         g = rnd[3:0];
         b = rnd[6:4];
         x = rnd[15:8];
         f = rnd[23:16];
         pa = addr(bop_pkg::IO_BASE, {4'h0, g});
         wr(pa, x);
         wr(bop_pkg::FLAGS_ADDR, f);
         run(mk(bop_pkg::IO_BIT_SET_OP, b, 4'h0, g, 2'h0), 2); // timing
         x[b] = 1'b1;
         rdc("io set", pa, x); // bit forced high
         run(mk(bop_pkg::IO_BIT_CLEAR_OP, b, 4'h0, g, 2'h0), 2); // timing
         x[b] = 1'b0;
         rdc("io clear", pa, x); // bit forced low
         rdc("io flags", bop_pkg::FLAGS_ADDR, f); // flags kept
      end
      $display("test io bits done");
      for (int k = 0; k < 15; k++) begin
         rnd = lfsr_nx(rnd);
         op = bop_pkg::LOGICAL_LEFT_SHIFT_OP + 4'(k % 5);
         x = (k < 5) ? 8'h81 : (k < 10) ? 8'h00 : rnd[7:0];
         g = rnd[11:8];
         f = rnd[23:16];
         pa = addr(bop_pkg::WREG_BASE, {4'h0, g});
         wr(pa, x);
         wr(bop_pkg::FLAGS_ADDR, f);
         run(mk(op, 3'h0, g, 4'h0, 2'h0), 1); // one cycle
         s = sh_ref(op, x, f);
         rdc("shift data", pa, s[7:0]); // result
         rdc("shift flags", bop_pkg::FLAGS_ADDR, s[15:8]); // flags
      end
      $display("test shifts done");
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr_nx(rnd);
         f = rnd[7:0];
         f[k] = 1'b0;
         wr(bop_pkg::FLAGS_ADDR, f);
         run(mk(bop_pkg::INDEXED_FLAG_SET_OP, 3'(k), 4'h0, 4'h0, 2'h0),
            1); // one cycle
         f[k] = 1'b1;
         rdc("flag set", bop_pkg::FLAGS_ADDR, f); // single flag
         run(mk(bop_pkg::INDEXED_FLAG_CLEAR_OP, 3'(k), 4'h0, 4'h0, 2'h0),
            1); // one cycle
         f[k] = 1'b0;
         rdc("flag clear", bop_pkg::FLAGS_ADDR, f); // single flag
      end
      rnd = lfsr_nx(rnd);
      f = {1'b0, rnd[6:0]};
      wr(bop_pkg::FLAGS_ADDR, f);
      run(mk(bop_pkg::GLOBAL_IRQ_ON_OP, 3'h0, 4'h0, 4'h0, 2'h0), 1);
      rdc("irq on", bop_pkg::FLAGS_ADDR, f | 8'h80); // only i flag
      run(mk(bop_pkg::GLOBAL_IRQ_OFF_OP, 3'h0, 4'h0, 4'h0, 2'h0), 1);
      rdc("irq off", bop_pkg::FLAGS_ADDR, f); // only i flag
      $display("test flags done");
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr_nx(rnd);
         x = rnd[7:0];
         f = rnd[15:8];
         b = rnd[18:16];
         g = rnd[23:20];
         pa = addr(bop_pkg::WREG_BASE, {4'h0, g});
         wr(pa, x);
         wr(bop_pkg::FLAGS_ADDR, f);
         run(mk(bop_pkg::BIT_TO_TRANSFER_FLAG_OP, b, g, 4'h0, 2'h0), 1);
         f[bop_pkg::FLG_T] = x[b];
         rdc("bit to t", bop_pkg::FLAGS_ADDR, f); // only t flag
         b = ~b;
         run(mk(bop_pkg::TRANSFER_FLAG_TO_BIT_OP, b, g, 4'h0, 2'h0), 1);
         x[b] = f[bop_pkg::FLG_T];
         rdc("t to bit", pa, x); // bit load
         run(mk(bop_pkg::NIBBLE_SWAP_OP, 3'h0, g, 4'h0, 2'h0), 1);
         rdc("swap", pa, {x[3:0], x[7:4]}); // nibbles exchanged
         rdc("bit flags", bop_pkg::FLAGS_ADDR, f); // flags kept
      end
      $display("test bit transfer done");
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr_nx(rnd);
         op = k[0] ? bop_pkg::INDIRECT_LOAD_DEC_OP
            : bop_pkg::INDIRECT_LOAD_INC_OP;
         x = (k < 2) ? 8'hFF : rnd[7:0];
         m = rnd[15:8];
         f = rnd[23:16];
         g = rnd[27:24];
         pa = addr(bop_pkg::PTR_BASE, 8'(k % 3));
         wr(addr(bop_pkg::MEM_BASE, x), m);
         wr(addr(bop_pkg::MEM_BASE, x - 8'h01), ~m);
         wr(addr(bop_pkg::MEM_BASE, x + 8'h01), ~m);
         wr(bop_pkg::FLAGS_ADDR, f);
         wr(pa, k[0] ? x + 8'h01 : x);
         run(mk(op, 3'h0, g, 4'h0, 2'(k % 3)), 2); // two cycles
         rdc("load data", addr(bop_pkg::WREG_BASE, {4'h0, g}),
            m); // read address
         rdc("pointer", pa, k[0] ? x : x + 8'h01); // pointer step
         rdc("load flags", bop_pkg::FLAGS_ADDR, f); // flags kept
      end
      $display("test loads done");
      for (int k = 0; k < 3; k++) begin
         xfer(1'b0, bad[k], bop_pkg::WORD_ZERO);
         chk8("bad addr err", 8'h01, {7'h00, er});
         chk8("bad addr data", 8'h00, rd[7:0]);
      end
      c = mk(bop_pkg::IO_BIT_SET_OP, 3'h5, 4'h0, 4'h3, 2'h0);
      xfer(1'b1, bop_pkg::CMD_ADDR, c);
      rdc("status busy", bop_pkg::STAT_ADDR, 8'h01); // second cycle
      xfer(1'b1, bop_pkg::CMD_ADDR, c);
      xfer(1'b1, bop_pkg::CMD_ADDR, bop_pkg::WORD_ZERO);
      chk8("busy cmd err", 8'h01, {7'h00, er}); // refused while busy
      rdc("cmd readback", bop_pkg::CMD_ADDR, c[7:0]); // op kept
      rdc("status idle", bop_pkg::STAT_ADDR, 8'h00); // two cycles
      $display("test refusals done");
      final_report();
   end
endmodule
